// *** uart_channel_mode_control.sv ***
// Mode registers, line mode steering and flow control for two serial channels
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
//
// Notes on behaviour
// - After reset or pointer-reset command the pointer selects mode register one.
// - Accessing mode register one moves the pointer to two; register two keeps it.
// - Receiver flow control drops request-to-send on start bit with full FIFO, latch kept.
// - Interrupt select picks ready or FIFO-full, also driven on port bit four.
// - Character mode shows top character errors; block mode ORs since error reset.
// - With or forced parity adds and checks parity; code 11 is multidrop.
// - Parity type selects odd/even, forced value, or address/data polarity.
// - Length field sets data bits, not counting start, parity and stop.
// - Mode field: normal, automatic echo, local loopback, remote loopback.
// - Echo re-clocks received data out, checks errors, echoes break and stop.
// - Echo hides transmitter ready and empty and blocks host transmit writes.
// - Local loopback feeds transmitter to receiver, holds pin high, ignores input.
// - Remote loopback echoes, hides data from host, suppresses errors and checks.
// - Mode changes act at once, except echo kept through a sampled stop bit.
// - Transmit RTS control clears request-to-send one bit after pending disable drains.
// - Clear-to-send control gates each character start; otherwise input ignored.
// - Stop length field sets stop bits in sixteenths, range depends on length.
// - Receiver checks only the centre of the first stop bit.
// - With external one-times clock, stop bit 3 picks one or two stop bits.
// - Channel B repeats all of this on its own pins and registers.
// - Every word read at index two toggles the baud table select.
// - Miscellaneous command 001 returns the pointer to mode register one.
module uart_channel_mode_control (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Channel cores and pins
	input wire mode_pkg::chan_in_t chanIn [mode_pkg::CHANNELS],
	output mode_pkg::chan_out_t chanOut [mode_pkg::CHANNELS],
	// Baud table select
	output logic baudHighSet
);
	import mode_pkg::*;

	// ********************************
	// Helper functions
	// ********************************
	function automatic logic echoing(input chan_mode_t m);
		echoing = (m == MODE_ECHO) || (m == MODE_REMOTE);
	endfunction

	function automatic logic [2:0] pickIdx(input int c, input logic [2:0] a, input logic [2:0] b);
		pickIdx = (c == 0) ? a : b;
	endfunction

	// Stop length in sixteenths of a bit
	function automatic logic [5:0] stopLength(input logic [3:0] code, input logic [1:0] len,
		input logic ext1x);
		logic [5:0] base;
		base = STOP_LONG_BASE;
		if (ext1x) begin
			stopLength = code[M2_STOP_LONG] ? STOP_TWO_1X : STOP_ONE_1X;
		end else begin
			if (len != LEN_FIVE && !code[M2_STOP_LONG]) begin
				base = STOP_SHORT_BASE;
			end
			if (len != LEN_FIVE) begin
				stopLength = base + {2'h0, code};
			end else begin
				stopLength = STOP_LONG_BASE + {2'h0, code};
			end
		end
	endfunction

	function automatic logic [31:0] statusWord(input chan_state_t s, input chan_out_t o,
		input chan_in_t i);
		statusWord = 32'h0;
		statusWord[ST_RX_READY] = i.rxReady;
		statusWord[ST_FIFO_FULL] = i.fifoFull;
		statusWord[ST_TX_READY] = o.txRdyFlag;
		statusWord[ST_TX_EMPTY] = o.txEmptyFlag;
		statusWord[ST_ERR_LSB +: 3] = o.errFlags;
		statusWord[ST_POINTER] = (s.ptr == PTR_SECOND);
		statusWord[ST_TX_EN] = s.txEn;
		statusWord[ST_RX_EN] = s.rxEn;
		statusWord[ST_RTS_N] = o.request_to_send_n;
		statusWord[ST_ECHO_HOLD] = s.echoHold;
	endfunction

	// ********************************
	// State
	// ********************************
	bus_state_t bus;
	bus_state_t next_bus;
	logic [31:0] next_hrdata;
	logic next_hreadyout;
	logic next_baudHighSet;
	chan_state_t chan [CHANNELS];
	chan_state_t next_chan [CHANNELS];
	chan_out_t next_chanOut [CHANNELS];
	logic doWrite;
	logic doRead;

	assign doWrite = bus.pending && bus.pendWrite && bus.pendMapped;
	assign doRead = bus.pending && !bus.pendWrite && bus.pendMapped;

	// ********************************
	// Bus slave
	// ********************************
	// Every transfer gets one wait state so that a read sees all earlier writes
	always_comb begin
		logic acceptNow;
		logic chanSel;
		acceptNow = hsel && htrans[1] && hready;
		chanSel = bus.pendIdx[2];
		next_bus = bus;
		next_bus.pending = acceptNow;
		next_hreadyout = !acceptNow;
		next_hrdata = hrdata;
		next_baudHighSet = baudHighSet;
		if (acceptNow) begin
			next_bus.pendIdx = haddr[ADDR_MSB:ADDR_LSB];
			next_bus.pendWrite = hwrite;
			next_bus.pendMapped = (haddr[31:ADDR_MSB + 1] == 27'h0) && (haddr[1:0] == 2'h0)
				&& (hsize == HSIZE_WORD);
		end
		if (bus.pending) begin
			next_hrdata = 32'h0;
		end
		if (doRead) begin
			unique case (bus.pendIdx)
				IDX_MODE_A, IDX_MODE_B: begin
					next_hrdata[7:0] = (chan[chanSel].ptr == PTR_FIRST) ?
						chan[chanSel].modeOne : chan[chanSel].modeTwo;
				end
				IDX_STATUS_A, IDX_STATUS_B: begin
					next_hrdata = statusWord(chan[chanSel], chanOut[chanSel], chanIn[chanSel]);
				end
				IDX_BAUD_TOGGLE: begin
					next_hrdata[0] = baudHighSet;
					next_baudHighSet = !baudHighSet;
				end
				IDX_OUT_LATCH: begin
					for (int c = 0; c < CHANNELS; c++) begin
						next_hrdata[LATCH_BIT0 + c] = chan[c].rtsLatch;
						next_hrdata[OPCFG_BIT0 + c] = chan[c].opFourCfg;
					end
				end
				IDX_CMD_A, IDX_CMD_B: begin
					next_hrdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus <= '0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			baudHighSet <= 1'b0;
		end else begin
			bus <= next_bus;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= HRESP_OKAY;
			baudHighSet <= next_baudHighSet;
		end
	end

	// ********************************
	// Channel control, both channels alike
	// ********************************
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			logic wrMode;
			logic rdMode;
			logic wrCmd;
			logic wrLatch;
			logic [2:0] misc;
			chan_mode_t wantMode;
			chan_mode_t m;
			logic [1:0] par;
			wantMode = MODE_NORMAL;
			m = MODE_NORMAL;
			par = 2'h0;
			wrMode = doWrite && (bus.pendIdx == pickIdx(c, IDX_MODE_A, IDX_MODE_B));
			rdMode = doRead && (bus.pendIdx == pickIdx(c, IDX_MODE_A, IDX_MODE_B));
			wrCmd = doWrite && (bus.pendIdx == pickIdx(c, IDX_CMD_A, IDX_CMD_B));
			wrLatch = doWrite && (bus.pendIdx == IDX_OUT_LATCH);
			misc = hwdata[6:4];
			next_chan[c] = chan[c];

			// ********************************
			// Mode registers behind the pointer
			// ********************************
			if (wrMode && chan[c].ptr == PTR_FIRST) begin
				next_chan[c].modeOne = hwdata[7:0];
			end
			if (wrMode && chan[c].ptr == PTR_SECOND) begin
				next_chan[c].modeTwo = hwdata[7:0];
			end
			if ((wrMode || rdMode) && chan[c].ptr == PTR_FIRST) begin
				next_chan[c].ptr = PTR_SECOND;
			end
			if (wrCmd && misc == MISC_PTR_RESET) begin
				next_chan[c].ptr = PTR_FIRST;
			end

			// ********************************
			// Transmitter disable waits for the shift and holding registers to drain
			// ********************************
			if (chan[c].txDisPend && chanIn[c].txEmptyCore) begin
				next_chan[c].txEn = 1'b0;
				next_chan[c].txDisPend = 1'b0;
				next_chan[c].rtsWait = chan[c].modeTwo[M2_TX_RTS];
			end
			if (chan[c].rtsWait && chanIn[c].txBitTick) begin
				next_chan[c].rtsWait = 1'b0;
				next_chan[c].rtsLatch = 1'b0;
			end
			// Disable and enable in one write leaves the part disabled
			if (wrCmd && hwdata[CMD_TX_DIS]) begin
				if (chanIn[c].txEmptyCore) begin
					next_chan[c].txEn = 1'b0;
				end else begin
					next_chan[c].txDisPend = 1'b1;
				end
			end else if (wrCmd && hwdata[CMD_TX_EN]) begin
				next_chan[c].txEn = 1'b1;
				next_chan[c].txDisPend = 1'b0;
				next_chan[c].rtsWait = 1'b0;
			end
			if (wrCmd && hwdata[CMD_RX_DIS]) begin
				next_chan[c].rxEn = 1'b0;
			end else if (wrCmd && hwdata[CMD_RX_EN]) begin
				next_chan[c].rxEn = 1'b1;
			end
			// A software write of the latch overrides the automatic clear
			if (wrLatch) begin
				next_chan[c].rtsLatch = hwdata[LATCH_BIT0 + c];
				next_chan[c].opFourCfg = hwdata[OPCFG_BIT0 + c];
			end

			// ********************************
			// Receiver flow control, the latch bit itself is left alone
			// ********************************
			if (!chan[c].modeOne[M1_RX_RTS] || !chanIn[c].fifoFull) begin
				next_chan[c].rtsBlock = 1'b0;
			end else if (chanIn[c].rxStartValid) begin
				next_chan[c].rtsBlock = 1'b1;
			end

			// ********************************
			// Error accumulation, a new error wins over the reset command
			// ********************************
			if (wrCmd && misc == MISC_ERR_RESET) begin
				next_chan[c].errAcc = 3'h0;
			end
			if (chanIn[c].topAdvance) begin
				next_chan[c].errAcc = next_chan[c].errAcc | chanIn[c].topErr;
			end

			// ********************************
			// Effective line mode
			// ********************************
			wantMode = chan_mode_t'(next_chan[c].modeTwo[7:6]);
			if (chan[c].echoHold) begin
				if (!chanIn[c].rxStopPhase) begin
					next_chan[c].echoHold = 1'b0;
					next_chan[c].effMode = wantMode;
				end
			end else if (echoing(chan[c].effMode) && !echoing(wantMode)
				&& chanIn[c].rxStopPhase && chan[c].txEn) begin
				next_chan[c].echoHold = 1'b1;
			end else begin
				next_chan[c].effMode = wantMode;
			end

			// ********************************
			// Outputs follow the next state so they change on the same edge
			// ********************************
			m = next_chan[c].effMode;
			par = next_chan[c].modeOne[4:3];
			next_chanOut[c].serialOut = chanIn[c].txCoreOut;
			unique case (m)
				MODE_NORMAL: next_chanOut[c].serialOut = chanIn[c].txCoreOut;
				MODE_ECHO: next_chanOut[c].serialOut = chanIn[c].rxPin;
				MODE_LOCAL: next_chanOut[c].serialOut = 1'b1;
				MODE_REMOTE: next_chanOut[c].serialOut = chanIn[c].rxPin;
			endcase
			next_chanOut[c].rxSerialIn = (m == MODE_LOCAL) ?
				chanIn[c].txCoreOut : chanIn[c].rxPin;
			next_chanOut[c].txUsesRxClk = echoing(m);
			next_chanOut[c].rxUsesTxClk = (m == MODE_LOCAL);
			next_chanOut[c].txHostWriteEn = !echoing(m);
			next_chanOut[c].txEnable = next_chan[c].txEn;
			next_chanOut[c].rxEnable = next_chan[c].rxEn;
			next_chanOut[c].txRdyFlag = (m != MODE_ECHO) && chanIn[c].txRdyCore;
			next_chanOut[c].txEmptyFlag = (m != MODE_ECHO) && chanIn[c].txEmptyCore;
			next_chanOut[c].request_to_send_n = !(next_chan[c].rtsLatch && !next_chan[c].rtsBlock);
			next_chanOut[c].rxIntSource = next_chan[c].modeOne[M1_INT_SEL] ?
				chanIn[c].fifoFull : chanIn[c].rxReady;
			// Port pins are active low, idle high when not configured
			next_chanOut[c].outPortFour = next_chan[c].opFourCfg ?
				!next_chanOut[c].rxIntSource : 1'b1;
			next_chanOut[c].parityOn = (par == PAR_WITH) || (par == PAR_FORCE);
			next_chanOut[c].parityForce = (par == PAR_FORCE);
			next_chanOut[c].parityType = (par != PAR_NONE) &&
				next_chan[c].modeOne[M1_PAR_TYPE];
			next_chanOut[c].multidrop = (par == PAR_MULTIDROP);
			next_chanOut[c].rxCheckParity = next_chanOut[c].parityOn
				&& (m != MODE_REMOTE);
			next_chanOut[c].rxCheckFraming = (m != MODE_REMOTE);
			next_chanOut[c].rxToHost = (m != MODE_REMOTE);
			next_chanOut[c].ctsGrant = !next_chan[c].modeTwo[M2_CTS] || !chanIn[c].remote_clear_to_send_n;
			if (m == MODE_REMOTE) begin
				next_chanOut[c].errFlags = 3'h0;
			end else if (next_chan[c].modeOne[M1_ERR_BLOCK]) begin
				next_chanOut[c].errFlags = next_chan[c].errAcc;
			end else begin
				next_chanOut[c].errFlags = chanIn[c].topErr;
			end
			next_chanOut[c].dataBits = DATA_BITS_MIN + {2'h0, next_chan[c].modeOne[1:0]};
			// Stop bit centre is counted in bit times after the start bit
			next_chanOut[c].stopCheckBit = next_chanOut[c].dataBits
				+ {3'h0, next_chanOut[c].parityOn};
			next_chanOut[c].stopSixteenths = stopLength(next_chan[c].modeTwo[3:0],
				next_chan[c].modeOne[1:0], chanIn[c].txExt1x);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int c = 0; c < CHANNELS; c++) begin
				chan[c] <= '{modeOne: MODE_RESET, modeTwo: MODE_RESET, ptr: PTR_FIRST,
					effMode: MODE_NORMAL, errAcc: 3'h0, default: 1'b0};
				chanOut[c] <= '{serialOut: 1'b1, rxSerialIn: 1'b1, txHostWriteEn: 1'b1,
					request_to_send_n: 1'b1, outPortFour: 1'b1, rxCheckFraming: 1'b1, rxToHost: 1'b1,
					ctsGrant: 1'b1, errFlags: 3'h0, dataBits: DATA_BITS_MIN,
					stopCheckBit: DATA_BITS_MIN, stopSixteenths: STOP_SHORT_BASE,
					default: 1'b0};
			end
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				chan[c] <= next_chan[c];
				chanOut[c] <= next_chanOut[c];
			end
		end
	end

endmodule // uart_channel_mode_control

// *** mode_pkg.sv ***
// Shared constants, types and register map of the channel mode control block
package mode_pkg;

	// ********************************
	// Sizes
	// ********************************
	localparam int CHANNELS = 2;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 4;

	// ********************************
	// Register indices, byte address is four times the index
	// ********************************
	localparam logic [2:0] IDX_MODE_A = 3'h0;
	localparam logic [2:0] IDX_STATUS_A = 3'h1;
	localparam logic [2:0] IDX_BAUD_TOGGLE = 3'h2;
	localparam logic [2:0] IDX_CMD_A = 3'h3;
	localparam logic [2:0] IDX_MODE_B = 3'h4;
	localparam logic [2:0] IDX_STATUS_B = 3'h5;
	localparam logic [2:0] IDX_OUT_LATCH = 3'h6;
	localparam logic [2:0] IDX_CMD_B = 3'h7;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// ********************************
	// Mode register fields
	// ********************************
	localparam int M1_RX_RTS = 7;
	localparam int M1_INT_SEL = 6;
	localparam int M1_ERR_BLOCK = 5;
	localparam int M1_PAR_TYPE = 2;
	localparam int M2_TX_RTS = 5;
	localparam int M2_CTS = 4;
	localparam int M2_STOP_LONG = 3;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [1:0] PAR_WITH = 2'h0;
	localparam logic [1:0] PAR_FORCE = 2'h1;
	localparam logic [1:0] PAR_NONE = 2'h2;
	localparam logic [1:0] PAR_MULTIDROP = 2'h3;
	localparam logic [3:0] DATA_BITS_MIN = 4'h5;
	localparam logic [1:0] LEN_FIVE = 2'h0;
	localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
	localparam logic [5:0] STOP_LONG_BASE = 6'h11;
	localparam logic [5:0] STOP_ONE_1X = 6'h10;
	localparam logic [5:0] STOP_TWO_1X = 6'h20;

	// ********************************
	// Command register fields
	// ********************************
	localparam int CMD_TX_DIS = 3;
	localparam int CMD_TX_EN = 2;
	localparam int CMD_RX_DIS = 1;
	localparam int CMD_RX_EN = 0;
	localparam logic [2:0] MISC_PTR_RESET = 3'h1;
	localparam logic [2:0] MISC_ERR_RESET = 3'h4;

	// ********************************
	// Output latch register and status bits
	// ********************************
	localparam int LATCH_BIT0 = 0;
	localparam int OPCFG_BIT0 = 4;
	localparam int ST_RX_READY = 0;
	localparam int ST_FIFO_FULL = 1;
	localparam int ST_TX_READY = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_ERR_LSB = 4;
	localparam int ST_POINTER = 8;
	localparam int ST_TX_EN = 9;
	localparam int ST_RX_EN = 10;
	localparam int ST_RTS_N = 11;
	localparam int ST_ECHO_HOLD = 12;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [1:0] {MODE_NORMAL, MODE_ECHO, MODE_LOCAL, MODE_REMOTE} chan_mode_t;
	typedef enum logic {PTR_FIRST, PTR_SECOND} ptr_t;

	typedef struct packed {
		logic rxPin;
		logic txCoreOut;
		logic remote_clear_to_send_n;
		logic rxReady;
		logic fifoFull;
		logic rxStartValid;
		logic topAdvance;
		logic [2:0] topErr;
		logic txRdyCore;
		logic txEmptyCore;
		logic txBitTick;
		logic rxStopPhase;
		logic txExt1x;
	} chan_in_t;

	typedef struct packed {
		logic serialOut;
		logic rxSerialIn;
		logic txUsesRxClk;
		logic rxUsesTxClk;
		logic txHostWriteEn;
		logic txEnable;
		logic rxEnable;
		logic txRdyFlag;
		logic txEmptyFlag;
		logic request_to_send_n;
		logic rxIntSource;
		logic outPortFour;
		logic parityOn;
		logic parityForce;
		logic parityType;
		logic multidrop;
		logic rxCheckParity;
		logic rxCheckFraming;
		logic rxToHost;
		logic ctsGrant;
		logic [2:0] errFlags;
		logic [3:0] dataBits;
		logic [3:0] stopCheckBit;
		logic [5:0] stopSixteenths;
	} chan_out_t;

	typedef struct packed {
		logic [7:0] modeOne;
		logic [7:0] modeTwo;
		ptr_t ptr;
		logic txEn;
		logic rxEn;
		logic txDisPend;
		logic rtsLatch;
		logic opFourCfg;
		logic rtsBlock;
		logic rtsWait;
		logic echoHold;
		logic [2:0] errAcc;
		chan_mode_t effMode;
	} chan_state_t;

	typedef struct packed {
		logic pending;
		logic pendWrite;
		logic pendMapped;
		logic [2:0] pendIdx;
	} bus_state_t;

endpackage

// *** mode_asserts.sv ***
// Concurrent checks on the ports of the channel mode control block
`timescale 1ns/10ps
module mode_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Channels
	input wire mode_pkg::chan_in_t chanIn [mode_pkg::CHANNELS],
	input wire mode_pkg::chan_out_t chanOut [mode_pkg::CHANNELS],
	input wire logic baudHighSet
);
	import mode_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ****************************************
	// Bus
	// ****************************************
	logic take;
	assign take = hsel && htrans[1] && hready;
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("bus response not okay");
	a_ready_once: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("ready not low for exactly one cycle");
	// A word read at index two must flip the baud table
	a_baud_toggle: assert property (take && !hwrite && haddr == 32'h8 && hsize == HSIZE_WORD
		|-> ##2 baudHighSet != $past(baudHighSet, 2)) else $error("baud select did not toggle");
	// ****************************************
	// Channel modes
	// ****************************************
	a_loop_high: assert property (chanOut[0].rxUsesTxClk |-> chanOut[0].serialOut)
		else $error("loopback pin not high");
	a_loop_feed: assert property (chanOut[1].rxUsesTxClk
		|-> chanOut[1].rxSerialIn == $past(chanIn[1].txCoreOut)) else $error("loop feed wrong");
	a_echo_blocks: assert property (chanOut[0].txUsesRxClk |-> !chanOut[0].txHostWriteEn
		&& chanOut[0].serialOut == $past(chanIn[0].rxPin)) else $error("echo path wrong");
	a_len_range: assert property (chanOut[0].dataBits inside {[4'h5:4'h8]}
		&& chanOut[0].stopCheckBit == chanOut[0].dataBits + chanOut[0].parityOn)
		else $error("length or stop check position wrong");
	// The length field moves only at the end of a bus wait state
	a_len_moves: assert property ($changed(chanOut[0].dataBits) |-> !$past(hreadyout))
		else $error("length changed without a write");
	a_int_source: assert property ($past(chanIn[0].rxReady) == $past(chanIn[0].fifoFull)
		|-> chanOut[0].rxIntSource == $past(chanIn[0].rxReady)) else $error("int source wrong");
	c_echo: cover property (chanOut[0].txUsesRxClk);
	c_loop_b: cover property (chanOut[1].rxUsesTxClk);
	c_baud: cover property (take && !hwrite && haddr == 32'h8);
endmodule // mode_asserts

bind uart_channel_mode_control mode_asserts i_chk (.clk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .chanIn, .chanOut,
	.baudHighSet);

// *** remote_serial.sv ***
// Remote serial transmitter that starts a frame only while allowed to send
`timescale 1ns/10ps
module remote_serial (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Flow control from the local device, low allows a new frame
	input wire logic request_to_send_n,
	// Serial line toward the local receiver
	output logic rxPin
);
	logic [9:0] frame;
	logic [3:0] bitCnt;
	logic [1:0] div;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			frame <= 10'h3ff;
			bitCnt <= 4'h0;
			div <= 2'h0;
			rxPin <= 1'h1;
		end else begin
			div <= div + 2'h1;
			if (div == 2'h3) begin
				if (bitCnt != 4'h0) begin
					rxPin <= frame[0];
					frame <= {1'h1, frame[9:1]};
					bitCnt <= bitCnt - 4'h1;
				end else if (!request_to_send_n) begin
					frame <= {1'h1, 8'h5a, 1'h0};
					bitCnt <= 4'ha;
				end else begin
					rxPin <= 1'h1;
				end
			end
		end
	end
endmodule // remote_serial

// *** tb_top.sv ***
// Self-checking bench for the channel mode control block
`timescale 1ns/10ps
module tb_top;
	import mode_pkg::*;
	typedef struct packed {
		logic [7:0] m1;
		logic [7:0] m2;
		logic [3:0] bits;
		logic md;
		logic frc;
		logic [5:0] stop;
		logic wrEn;
		logic toHost;
	} row_t;
	// One row per parity code, length code and channel mode
	localparam row_t ROWS [4] = '{
		'{8'h00, 8'h00, 4'h5, 1'h0, 1'h0, 6'h11, 1'h1, 1'h1},
		'{8'h09, 8'h47, 4'h6, 1'h0, 1'h1, 6'h10, 1'h0, 1'h1},
		'{8'h12, 8'h88, 4'h7, 1'h0, 1'h0, 6'h19, 1'h1, 1'h1},
		'{8'h1b, 8'hcf, 4'h8, 1'h1, 1'h0, 6'h20, 1'h0, 1'h0}};
	logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, baudHighSet, remRx, p;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	chan_in_t chanIn [CHANNELS];
	chan_out_t chanOut [CHANNELS];
	int mismatches, total_checks;
	assign hready = hreadyout;
	uart_channel_mode_control i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chanIn(chanIn),
		.chanOut(chanOut), .baudHighSet(baudHighSet));
	remote_serial i_rem (.clk(clk), .reset_n(reset_n), .request_to_send_n(chanOut[0].request_to_send_n), .rxPin(remRx));
	// ****************************************
	// Clock, line inputs and hang guard
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		chanIn[0].txCoreOut <= ~chanIn[0].txCoreOut;
		chanIn[1].txCoreOut <= ~chanIn[1].txCoreOut;
		chanIn[0].rxPin <= remRx;
	end
	initial begin
		repeat (3000) @(posedge clk);
		$display("Error at %0t: timeout", $time);
		mismatches++;
		end_sim();
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= addr;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		// No wait count is assumed, only the hang guard ends a stuck transfer
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_n = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		chanIn[0] = '0;
		chanIn[1] = '0;
		chanIn[0].txRdyCore = 1'h1;
		mismatches = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		chk(chanOut[0].dataBits, 4'h5, "reset length");
		chk(chanOut[1].request_to_send_n, 1'h1, "reset rts");
		chk(baudHighSet, 1'h0, "reset baud");
		chk(hreadyout, 1'h1, "reset ready");
		reset_n <= 1'h1;
		$display("Test reset done");
		ahb(1'h1, 32'h0, 32'h80);
		ahb(1'h1, 32'h18, 32'h11);
		chk(chanOut[0].request_to_send_n, 1'h0, "rts asserted");
		@(posedge clk);
		chanIn[0].fifoFull <= 1'h1;
		chanIn[0].rxReady <= 1'h1;
		chanIn[0].rxStartValid <= 1'h1;
		@(posedge clk);
		chanIn[0].rxStartValid <= 1'h0;
		@(posedge clk);
		#1;
		chk(chanOut[0].request_to_send_n, 1'h1, "rts dropped");
		chk(chanOut[0].outPortFour, 1'h0, "port four");
		ahb(1'h0, 32'h18, 32'h0);
		chk(rd[0], 1'h1, "latch kept");
		chk(chanOut[0].rxIntSource, 1'h1, "int source");
		chanIn[0].fifoFull <= 1'h0;
		chanIn[0].rxReady <= 1'h0;
		repeat (2) @(posedge clk);
		#1;
		chk(chanOut[0].request_to_send_n, 1'h0, "rts back");
		$display("Test flow control done");
		foreach (ROWS[i]) begin
			ahb(1'h1, 32'hc, 32'h10);
			ahb(1'h1, 32'h0, {24'h0, ROWS[i].m1});
			ahb(1'h1, 32'h0, {24'h0, ROWS[i].m2});
			chk(chanOut[0].dataBits, ROWS[i].bits, "length");
			chk(chanOut[0].multidrop, ROWS[i].md, "multidrop");
			chk(chanOut[0].parityForce, ROWS[i].frc, "force");
			chk(chanOut[0].stopSixteenths, ROWS[i].stop, "stop");
			chk(chanOut[0].txHostWriteEn, ROWS[i].wrEn, "host write");
			chk(chanOut[0].rxToHost, ROWS[i].toHost, "to host");
			chk(chanOut[0].rxCheckFraming, ROWS[i].toHost, "framing");
			chk(chanOut[0].txUsesRxClk, !ROWS[i].wrEn, "rx clock");
			chk(chanOut[0].txRdyFlag, ROWS[i].m2[7:6] != 2'h1, "ready hidden");
			ahb(1'h1, 32'hc, 32'h10);
			ahb(1'h0, 32'h0, 32'h0);
			chk(rd, {24'h0, ROWS[i].m1}, "read one");
			ahb(1'h0, 32'h0, 32'h0);
			chk(rd, {24'h0, ROWS[i].m2}, "read two");
		end
		$display("Test mode rows done");
		repeat (40) begin
			@(posedge clk);
			p = chanIn[0].rxPin;
			#1;
			chk(chanOut[0].serialOut, p, "echo out");
		end
		$display("Test remote loopback done");
		ahb(1'h1, 32'h1c, 32'h10);
		ahb(1'h1, 32'h10, 32'h03);
		chk(chanOut[1].dataBits, 4'h8, "chan b length");
		ahb(1'h0, 32'h14, 32'h0);
		chk(rd[ST_POINTER], 1'h1, "chan b pointer");
		ahb(1'h1, 32'h10, 32'h80);
		chk(chanOut[1].rxUsesTxClk, 1'h1, "chan b loop");
		$display("Test channel b done");
		ahb(1'h1, 32'hc, 32'h14);
		ahb(1'h1, 32'h0, 32'h20);
		ahb(1'h1, 32'h0, 32'h30);
		chanIn[0].topAdvance <= 1'h1;
		chanIn[0].topErr <= 3'h2;
		@(posedge clk);
		chanIn[0].topErr <= 3'h1;
		@(posedge clk);
		chanIn[0].topAdvance <= 1'h0;
		chanIn[0].topErr <= 3'h0;
		chanIn[0].remote_clear_to_send_n <= 1'h1;
		chanIn[0].txExt1x <= 1'h1;
		chanIn[0].txEmptyCore <= 1'h0;
		repeat (2) @(posedge clk);
		chk(chanOut[0].errFlags, 3'h3, "block errors");
		chk(chanOut[0].ctsGrant, 1'h0, "cts hold");
		chk(chanOut[0].stopSixteenths, 6'h10, "one stop 1x");
		ahb(1'h1, 32'hc, 32'h48);
		chk(chanOut[0].errFlags, 3'h0, "error reset");
		chk({chanOut[0].txEnable, chanOut[0].request_to_send_n}, 2'h2, "disable pending");
		chanIn[0].txEmptyCore <= 1'h1;
		@(posedge clk);
		chanIn[0].txBitTick <= 1'h1;
		@(posedge clk);
		chanIn[0].txBitTick <= 1'h0;
		chk({chanOut[0].txEnable, chanOut[0].request_to_send_n}, 2'h0, "rts holds a bit");
		@(posedge clk);
		chk(chanOut[0].request_to_send_n, 1'h1, "rts auto clear");
		$display("Test errors, cts and auto rts done");
		ahb(1'h0, 32'h8, 32'h0);
		chk({rd[0], baudHighSet}, 2'h1, "baud first");
		ahb(1'h0, 32'h8, 32'h0);
		chk({rd[0], baudHighSet}, 2'h2, "baud second");
		ahb(1'h0, 32'h22, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		$display("Test baud and unmapped done");
		end_sim();
	end
endmodule // tb_top
